/* src/tfr_consts.svh */
// constants for the task-file register block
`ifndef TFR_CONSTS_SVH
`define TFR_CONSTS_SVH
// register addresses: {cs0_n, cs1_n, da[2:0]} with chip selects active low
`define TFR_A_ERR_FEAT    5'h11
`define TFR_A_SEC_COUNT   5'h12
`define TFR_A_SEC_NUMBER  5'h13
`define TFR_A_UNIT_HEAD   5'h16
`define TFR_A_STAT_CMD    5'h17
`define TFR_A_ALT_DEVCTL  5'h0E
// unit/head fields
`define TFR_UH_LBA_BIT    6
`define TFR_UH_UNIT_BIT   4
`define TFR_UH_FIXED      8'hA0
// device control fields
`define TFR_DC_SOFT_RESET_BIT_BIT   2
`define TFR_DC_IRQDIS_BIT 1
// status fields
`define TFR_ST_BSY        7
`define TFR_ST_RDY        6
`define TFR_ST_DF         5
`define TFR_ST_DSC        4
`define TFR_ST_DRQ        3
`define TFR_ST_IDX        1
`define TFR_ST_ERR        0
// reset values
`define TFR_RST_SEC_COUNT 8'h01
`define TFR_RST_SEC_NUM   8'h01
`define TFR_RST_UNIT_HEAD 8'hA0
`define TFR_RST_STATUS    8'h50
`define TFR_DIAG_OK       8'h01
`define TFR_DIAG_MASK     8'h7F
`define TFR_FEAT_REVERT   8'hCC
`define TFR_FEAT_KEEP     8'h66
// error bit positions
`define TFR_ER_CRC        7
`define TFR_ER_UNC        6
`define TFR_ER_SECTOR_MISSING_FLAG       4
`define TFR_ER_ABORTED_FLAG       2
`define TFR_ER_TK0        1
`define TFR_ER_MARK_MISSING_FLAG       0
`define TFR_ER_MASK       8'hD7
`endif

/* src/tfr_pkg.sv */
// types for the task-file register block
package tfr_pkg;
  typedef struct packed {
    logic [1:0] sa;
    logic [1:0] sb;
    logic [1:0] sc;
    logic [1:0] sd;
    logic [1:0] se;
    logic [1:0] sf;
    logic [1:0] sg;
    logic [1:0] sh;
    logic [1:0] si;
    logic [1:0] sj;
    logic [1:0] sk;
    logic [1:0] sl;
    logic [1:0] sm;
    logic [1:0] sn;
    logic [1:0] so;
    logic [1:0] sp;
  } tfr_sync_t;
  typedef struct packed {
    logic [7:0] unit_head;
    logic [7:0] error_report;
    logic [7:0] feature_sel;
    logic [7:0] sec_count;
    logic [7:0] sec_number;
    logic       busy;
    logic       ready;
    logic       wfault;
    logic       seek_done;
    logic       dsc_frozen;
    logic       err;
    logic       irq_pend;
    logic       irq_dis;
    logic       soft_reset_bit;
    logic       revert_en;
    logic       rd_d;
    logic       wr_d;
    logic [7:0] dout;
    logic       dout_oe;
    logic       intrq;
    logic       cmd_pulse;
    logic [7:0] cmd_code;
    logic       soft_reset_bit_pulse;
    logic       revert_pulse;
    logic       transfer_request_flag;
  } tfr_state_t;
endpackage : tfr_pkg

/* src/tfr_regs.sv */
// task-file register group of a disk drive on the parallel host bus
// Summary of operation
// - unit/head: ones in 7,5; LBA, unit, head
// - unit select picks master or slave, match only
// - head bits updated at command completion
// - error bits: crc unc 0 sector_missing_flag 0 aborted_flag tk0 mark_missing_flag
// - error contents valid after every ordinary command
// - diagnostic code after reset or diagnostic
// - set crc, unc, sector missing on events
// - set abort, track zero, mark missing on events
// - sector count: 0 means 256, remainder at end
// - sector number updated to address bits 0-7
// - status bit layout; updated on error, completion
// - status read acknowledges pending interrupt
// - reads while busy return status
// - ready low until device accepts commands
// - write fault cleared by status read
// - seek done frozen after error until read, except low power mode forces it set
// - transfer request flag raised when data ready
// - error flag cleared when next command arrives
// - reset defaults 01h, 01h, A0h, 50h
// - reset waits for write cache flush
// - soft reset keeps parameters unless CCh enabled
// - interrupt only when enabled and selected
// - alternate status read does not acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "tfr_consts.svh"
module tfr_regs (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       hard_reset_n,
  input  wire logic       cs0_n,
  input  wire logic       cs1_n,
  input  wire logic [2:0] da,
  input  wire logic       dior_n,
  input  wire logic       diow_n,
  input  wire logic [7:0] dd_in,
  output var  logic [7:0] dd_out,
  output var  logic       dd_oe,
  output var  logic       intrq,
  input  wire logic       unit_position,
  input  wire logic       core_ready,
  input  wire logic       cache_flushed,
  input  wire logic       core_busy,
  input  wire logic       core_drq,
  input  wire logic       cmd_done,
  input  wire logic       cmd_error,
  input  wire logic [7:0] done_err_bits,
  input  wire logic [7:0] done_sec_count,
  input  wire logic [7:0] done_sec_number,
  input  wire logic [3:0] done_head,
  input  wire logic       diag_done,
  input  wire logic [7:0] diag_code,
  input  wire logic       write_fault_evt,
  input  wire logic       seek_start,
  input  wire logic       head_settled,
  input  wire logic       low_power_mode,
  input  wire logic       revolution_pulse,
  output var  logic       cmd_strobe,
  output var  logic [7:0] cmd_code,
  output var  logic [7:0] feature_select,
  output var  logic       soft_reset_evt,
  output var  logic       revert_defaults
);
  tfr_pkg::tfr_state_t st_ff;
  tfr_pkg::tfr_state_t nxt_st;
  tfr_pkg::tfr_sync_t  sy_ff;

  logic [4:0] addr;
  logic       rd_s;
  logic       wr_s;
  logic       rd_edge;
  logic       wr_edge;
  logic       hrst_s;
  logic       sel_me;
  logic [7:0] status_v;
  logic [7:0] rd_data;

  function automatic logic [7:0] tfr_status(input tfr_pkg::tfr_state_t s,
                                            input logic idx);
    logic [7:0] v;
    v = 8'h00;
    v[`TFR_ST_BSY] = s.busy;
    v[`TFR_ST_RDY] = s.ready;
    v[`TFR_ST_DF]  = s.wfault;
    v[`TFR_ST_DSC] = s.seek_done;
    v[`TFR_ST_DRQ] = s.transfer_request_flag;
    v[`TFR_ST_IDX] = idx;
    v[`TFR_ST_ERR] = s.err;
    return v;
  endfunction : tfr_status

  // two-stage synchronisers for every pin-side input except the data bus dd_in
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_ff <= '0;
      sy_ff.sa <= 2'h3;
      sy_ff.sb <= 2'h3;
      sy_ff.sc <= 2'h3;
      sy_ff.sd <= 2'h3;
      sy_ff.si <= 2'h3;
    end else begin
      sy_ff.sa <= {sy_ff.sa[0], cs0_n};
      sy_ff.sb <= {sy_ff.sb[0], cs1_n};
      sy_ff.sc <= {sy_ff.sc[0], dior_n};
      sy_ff.sd <= {sy_ff.sd[0], diow_n};
      sy_ff.se <= {sy_ff.se[0], da[0]};
      sy_ff.sf <= {sy_ff.sf[0], da[1]};
      sy_ff.sg <= {sy_ff.sg[0], da[2]};
      sy_ff.sh <= {sy_ff.sh[0], revolution_pulse};
      sy_ff.si <= {sy_ff.si[0], hard_reset_n};
      sy_ff.sj <= '0;
      sy_ff.sk <= '0;
      sy_ff.sl <= '0;
      sy_ff.sm <= '0;
      sy_ff.sn <= '0;
      sy_ff.so <= '0;
      sy_ff.sp <= '0;
    end
  end

  // data is sampled on strobe edges; the host holds it stable across them
  assign addr    = {sy_ff.sa[1], sy_ff.sb[1], sy_ff.sg[1], sy_ff.sf[1],
                    sy_ff.se[1]};
  assign rd_s    = ~sy_ff.sc[1];
  assign wr_s    = ~sy_ff.sd[1];
  assign hrst_s  = ~sy_ff.si[1];
  assign rd_edge = rd_s & ~st_ff.rd_d;
  assign wr_edge = ~wr_s & st_ff.wr_d;
  assign sel_me  = (st_ff.unit_head[`TFR_UH_UNIT_BIT] == unit_position);
  assign status_v = tfr_status(st_ff, sy_ff.sh[1]);

  always_comb begin
    rd_data = 8'h00;
    if (st_ff.busy) begin
      rd_data = status_v;
    end else if (addr == `TFR_A_ERR_FEAT) begin
      rd_data = st_ff.error_report & `TFR_ER_MASK;
    end else if (addr == `TFR_A_SEC_COUNT) begin
      rd_data = st_ff.sec_count;
    end else if (addr == `TFR_A_SEC_NUMBER) begin
      rd_data = st_ff.sec_number;
    end else if (addr == `TFR_A_UNIT_HEAD) begin
      rd_data = st_ff.unit_head;
    end else if (addr == `TFR_A_STAT_CMD) begin
      rd_data = status_v;
    end else if (addr == `TFR_A_ALT_DEVCTL) begin
      rd_data = status_v;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_d = rd_s;
    nxt_st.wr_d = wr_s;
    nxt_st.cmd_pulse = 1'b0;
    nxt_st.soft_reset_bit_pulse = 1'b0;
    nxt_st.revert_pulse = 1'b0;
    nxt_st.transfer_request_flag = core_drq;
    nxt_st.ready = core_ready;
    nxt_st.dout_oe = rd_s && sel_me;
    if (rd_edge) begin
      nxt_st.dout = rd_data;
    end

    // low power mode forces seek done set; otherwise it tracks the head unless an error has frozen it
    if (low_power_mode) begin
      nxt_st.seek_done = 1'b1;
    end else if (!st_ff.dsc_frozen) begin
      if (seek_start) begin
        nxt_st.seek_done = 1'b0;
      end else if (head_settled) begin
        nxt_st.seek_done = 1'b1;
      end
    end

    if (rd_edge && sel_me && !st_ff.busy && addr == `TFR_A_STAT_CMD) begin
      nxt_st.irq_pend = 1'b0;
      nxt_st.wfault = 1'b0;
      nxt_st.dsc_frozen = 1'b0;
    end
    // alternate status reads change nothing

    if (write_fault_evt) begin
      nxt_st.wfault = 1'b1;
    end

    // device control stays writable while busy, or soft reset never ends
    if (wr_edge && (!st_ff.busy || addr == `TFR_A_ALT_DEVCTL)) begin
      if (addr == `TFR_A_UNIT_HEAD) begin
        nxt_st.unit_head = dd_in | `TFR_UH_FIXED;
      end else if (sel_me && addr == `TFR_A_ERR_FEAT) begin
        nxt_st.feature_sel = dd_in;
        nxt_st.revert_en = (dd_in == `TFR_FEAT_REVERT) ? 1'b1 :
          (dd_in == `TFR_FEAT_KEEP) ? 1'b0 : st_ff.revert_en;
      end else if (sel_me && addr == `TFR_A_SEC_COUNT) begin
        nxt_st.sec_count = dd_in;
      end else if (sel_me && addr == `TFR_A_SEC_NUMBER) begin
        nxt_st.sec_number = dd_in;
      end else if (sel_me && addr == `TFR_A_STAT_CMD && !st_ff.transfer_request_flag) begin
        nxt_st.cmd_pulse = 1'b1;
        nxt_st.cmd_code = dd_in;
        nxt_st.err = 1'b0;
        nxt_st.busy = 1'b1;
      end else if (addr == `TFR_A_ALT_DEVCTL) begin
        nxt_st.irq_dis = dd_in[`TFR_DC_IRQDIS_BIT];
        if (st_ff.soft_reset_bit && !dd_in[`TFR_DC_SOFT_RESET_BIT_BIT]) begin
          nxt_st.soft_reset_bit_pulse = 1'b1;
          nxt_st.revert_pulse = st_ff.revert_en;
        end
        nxt_st.soft_reset_bit = dd_in[`TFR_DC_SOFT_RESET_BIT_BIT];
        if (dd_in[`TFR_DC_SOFT_RESET_BIT_BIT]) begin
          nxt_st.busy = 1'b1;
        end
      end
    end

    if (st_ff.soft_reset_bit) begin
      nxt_st.busy = 1'b1;
    end else if (st_ff.soft_reset_bit_pulse) begin
      // interface-only reset; programmed features survive unless CCh enabled revert_defaults
      nxt_st.sec_count = `TFR_RST_SEC_COUNT;
      nxt_st.sec_number = `TFR_RST_SEC_NUM;
      nxt_st.unit_head = `TFR_RST_UNIT_HEAD;
      nxt_st.error_report = `TFR_DIAG_OK;
      nxt_st.err = 1'b0;
      nxt_st.wfault = 1'b0;
      nxt_st.irq_pend = 1'b0;
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy && !st_ff.cmd_pulse && !core_busy &&
                 core_ready && cache_flushed) begin
      nxt_st.busy = 1'b0;
    end

    if (diag_done) begin
      nxt_st.error_report = diag_code;
      nxt_st.err = 1'b0;
      nxt_st.irq_pend = 1'b1;
    end else if (cmd_done) begin
      nxt_st.error_report = done_err_bits & `TFR_ER_MASK;
      nxt_st.err = cmd_error;
      nxt_st.sec_count = done_sec_count;
      nxt_st.sec_number = done_sec_number;
      nxt_st.unit_head = {st_ff.unit_head[7:4], done_head};
      nxt_st.dsc_frozen = cmd_error;
      nxt_st.irq_pend = 1'b1;
    end

    // event sets win over the acknowledge clear
    nxt_st.intrq = nxt_st.irq_pend && !nxt_st.irq_dis && sel_me;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.unit_head <= `TFR_RST_UNIT_HEAD;
      st_ff.error_report <= `TFR_DIAG_OK;
      st_ff.sec_count <= `TFR_RST_SEC_COUNT;
      st_ff.sec_number <= `TFR_RST_SEC_NUM;
      st_ff.busy <= 1'b1;
      st_ff.seek_done <= 1'b1;
      st_ff.rd_d <= 1'b0;
    end else if (hrst_s) begin
      // bus reset line: same defaults as power-on, held while asserted
      st_ff <= '0;
      st_ff.unit_head <= `TFR_RST_UNIT_HEAD;
      st_ff.error_report <= `TFR_DIAG_OK;
      st_ff.sec_count <= `TFR_RST_SEC_COUNT;
      st_ff.sec_number <= `TFR_RST_SEC_NUM;
      st_ff.busy <= 1'b1;
      st_ff.seek_done <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dd_out          = st_ff.dout;
  assign dd_oe           = st_ff.dout_oe;
  assign intrq           = st_ff.intrq;
  assign cmd_strobe      = st_ff.cmd_pulse;
  assign cmd_code        = st_ff.cmd_code;
  assign feature_select  = st_ff.feature_sel;
  assign soft_reset_evt  = st_ff.soft_reset_bit_pulse;
  assign revert_defaults = st_ff.revert_pulse;
endmodule : tfr_regs
`default_nettype wire

/* tb/tfr_host_model.sv */
// host controller model driving the parallel task-file bus
`timescale 1ns/10ps
`default_nettype none
module tfr_host_model (
  input  wire logic       sys_clk,
  output var  logic       cs0_n,
  output var  logic       cs1_n,
  output var  logic [2:0] da,
  output var  logic       dior_n,
  output var  logic       diow_n,
  output var  logic [7:0] dd_in,
  input  wire logic [7:0] dd_out
);
  initial begin
    {cs0_n, cs1_n, da} = 5'h1F;
    dior_n = 1'b1;
    diow_n = 1'b1;
    dd_in = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // strobe held 6 cycles, then 4 idle so the 2-ff synchronisers see it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    {cs0_n, cs1_n, da} = a;
    dd_in = d;
    diow_n = 1'b0;
    cyc(6);
    diow_n = 1'b1;
    cyc(4);
    dd_in = ~d;
    {cs0_n, cs1_n, da} = 5'h1F;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    {cs0_n, cs1_n, da} = a;
    dior_n = 1'b0;
    cyc(6);
    d = dd_out;
    dior_n = 1'b1;
    cyc(4);
    {cs0_n, cs1_n, da} = 5'h1F;
  endtask : rd
endmodule : tfr_host_model
`default_nettype wire

/* tb/tfr_regs_asserts.sv */
// port assertions for the task-file register block
`timescale 1ns/10ps
`default_nettype none
`include "tfr_consts.svh"
module tfr_regs_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       hard_reset_n,
  input wire logic       cs0_n,
  input wire logic       cs1_n,
  input wire logic [2:0] da,
  input wire logic       dior_n,
  input wire logic       diow_n,
  input wire logic       dd_oe,
  input wire logic       intrq,
  input wire logic       core_busy,
  input wire logic       cache_flushed,
  input wire logic       core_drq,
  input wire logic       cmd_done,
  input wire logic       cmd_strobe,
  input wire logic       soft_reset_evt,
  input wire logic       revert_defaults
);
  logic [4:0] addr;
  logic [3:0] wr_age_ff;
  logic [3:0] nxt_wr_age;
  assign addr = {cs0_n, cs1_n, da};
  // cycles since the write strobe was last low, saturating at 15
  always_comb nxt_wr_age = !diow_n ? 4'h0 : wr_age_ff + {3'h0, ~&wr_age_ff};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wr_age_ff <= 4'hF;
    else wr_age_ff <= nxt_wr_age;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property ($rose(rst_n) |-> !intrq && !dd_oe)
    else $error("output active after reset");
  cmd_source_a: assert property (cmd_strobe |->
    wr_age_ff inside {[4'h1:4'h7]} ##1 !cmd_strobe)
    else $error("command strobe without a write");
  drq_block_a: assert property (core_drq [*3] |=> !cmd_strobe)
    else $error("command taken during data request");
  soft_reset_bit_source_a: assert property (soft_reset_evt |->
    wr_age_ff inside {[4'h1:4'h7]} ##1 !soft_reset_evt)
    else $error("soft reset event without a write");
  revert_pair_a: assert property (revert_defaults |-> soft_reset_evt)
    else $error("revert without soft reset");
  alt_noack_a: assert property (intrq && hard_reset_n && !dior_n &&
    addr == `TFR_A_ALT_DEVCTL |=> intrq)
    else $error("alternate status read cleared interrupt");
  status_ack_a: assert property ((!dior_n && !core_busy &&
    cache_flushed && !cmd_done && addr == `TFR_A_STAT_CMD) [*6] |=> !intrq)
    else $error("status read left interrupt set");
  oe_release_a: assert property (dior_n [*5] |-> !dd_oe)
    else $error("data bus driven without read");
  cover property (cmd_strobe);
  cover property (revert_defaults);
  cover property (intrq && !dior_n && addr == `TFR_A_ALT_DEVCTL);
endmodule : tfr_regs_asserts
`default_nettype wire

/* tb/tfr_regs_tb_top.sv */
// self-checking bench for the task-file register block
`timescale 1ns/10ps
`default_nettype none
`include "tfr_consts.svh"
module tfr_regs_tb_top;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       hard_reset_n = 1'b1;
  logic       core_ready = 1'b0;
  logic       cache_flushed = 1'b1;
  logic       core_busy = 1'b0;
  logic       core_drq = 1'b0;
  logic       cmd_done = 1'b0;
  logic       cmd_error = 1'b0;
  logic       diag_done = 1'b0;
  logic       write_fault_evt = 1'b0;
  logic       seek_start = 1'b0;
  logic       head_settled = 1'b0;
  logic       low_power_mode = 1'b0;
  logic       revolution_pulse = 1'b0;
  logic [7:0] done_err_bits = 8'h00;
  logic [7:0] done_sec_count = 8'h00;
  logic [7:0] done_sec_number = 8'h00;
  logic [3:0] done_head = 4'h0;
  logic [7:0] diag_code = 8'h00;
  logic [7:0] code_seen;
  wire        cs0_n, cs1_n, dior_n, diow_n, dd_oe, intrq;
  wire        cmd_strobe, soft_reset_evt, revert_defaults;
  wire  [2:0] da;
  wire  [7:0] dd_in, dd_out, cmd_code;
  int         fail_count = 0;
  int         n_checks = 0;
  int         n_cmd = 0;
  int         n_rev = 0;
  int         cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  tfr_host_model host (.sys_clk(sys_clk), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out));
  tfr_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .hard_reset_n(hard_reset_n),
    .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n), .diow_n(diow_n),
    .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe), .intrq(intrq),
    .unit_position(1'b0), .core_ready(core_ready), .core_busy(core_busy),
    .cache_flushed(cache_flushed), .core_drq(core_drq), .cmd_done(cmd_done),
    .cmd_error(cmd_error), .done_err_bits(done_err_bits),
    .done_sec_count(done_sec_count), .done_sec_number(done_sec_number),
    .done_head(done_head), .diag_done(diag_done), .diag_code(diag_code),
    .write_fault_evt(write_fault_evt), .seek_start(seek_start),
    .head_settled(head_settled), .low_power_mode(low_power_mode),
    .revolution_pulse(revolution_pulse), .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code), .feature_select(), .soft_reset_evt(soft_reset_evt),
    .revert_defaults(revert_defaults));
  always @(posedge sys_clk) begin
    cycles++;
    n_cmd += int'(cmd_strobe === 1'b1);
    n_rev += int'(revert_defaults === 1'b1);
    if (cmd_strobe === 1'b1)
      code_seen = cmd_code;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask : rchk
  task automatic ichk(input logic exp);
    host.cyc(2);
    check({7'h0, intrq}, {7'h0, exp});
  endtask : ichk
  task automatic done(input logic e, input logic [7:0] eb, c, n,
                      input logic [3:0] h);
    {cmd_error, done_err_bits, done_sec_count} = {e, eb, c};
    {done_sec_number, done_head} = {n, h};
    cmd_done = 1'b1;
    core_busy = 1'b0;
    host.cyc(1);
    cmd_done = 1'b0;
    host.cyc(2);
  endtask : done
  task automatic soft_reset_bit(input logic [7:0] f);
    host.wr(`TFR_A_ERR_FEAT, f);
    host.wr(`TFR_A_ALT_DEVCTL, 8'h04);
    host.cyc(1000);
    host.wr(`TFR_A_ALT_DEVCTL, 8'h00);
    host.cyc(10);
  endtask : soft_reset_bit
  task automatic t_reset;
    rchk(`TFR_A_STAT_CMD, 8'h90);
    core_ready = 1'b1;
    host.cyc(4);
    rchk(`TFR_A_STAT_CMD, 8'h50);
    rchk(`TFR_A_SEC_COUNT, 8'h01);
    rchk(`TFR_A_SEC_NUMBER, 8'h01);
    rchk(`TFR_A_UNIT_HEAD, 8'hA0);
    rchk(`TFR_A_ERR_FEAT, 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cmd;
    host.wr(`TFR_A_SEC_COUNT, 8'h00);
    rchk(`TFR_A_SEC_COUNT, 8'h00);
    host.wr(`TFR_A_UNIT_HEAD, 8'hE5);
    rchk(`TFR_A_UNIT_HEAD, 8'hE5);
    core_busy = 1'b1;
    host.wr(`TFR_A_STAT_CMD, 8'h20);
    check(code_seen, 8'h20);
    rchk(`TFR_A_ERR_FEAT, 8'hD0);
    done(1'b1, 8'h14, 8'h03, 8'h7F, 4'hA);
    ichk(1'b1);
    rchk(`TFR_A_ALT_DEVCTL, 8'h51);
    ichk(1'b1);
    rchk(`TFR_A_ERR_FEAT, 8'h14);
    rchk(`TFR_A_SEC_COUNT, 8'h03);
    rchk(`TFR_A_SEC_NUMBER, 8'h7F);
    rchk(`TFR_A_UNIT_HEAD, 8'hEA);
    rchk(`TFR_A_STAT_CMD, 8'h51);
    ichk(1'b0);
    core_busy = 1'b1;
    host.wr(`TFR_A_STAT_CMD, 8'h20);
    rchk(`TFR_A_STAT_CMD, 8'hD0);
    done(1'b0, 8'hC3, 8'h00, 8'h01, 4'h0);
    rchk(`TFR_A_ERR_FEAT, 8'hC3);
    $display("test command done");
  endtask : t_cmd
  task automatic t_irq;
    write_fault_evt = 1'b1;
    host.cyc(1);
    write_fault_evt = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h70);
    rchk(`TFR_A_STAT_CMD, 8'h50);
    core_drq = 1'b1;
    host.cyc(3);
    rchk(`TFR_A_STAT_CMD, 8'h58);
    host.wr(`TFR_A_STAT_CMD, 8'h20);
    check(n_cmd[7:0], 8'h02);
    core_drq = 1'b0;
    host.wr(`TFR_A_ALT_DEVCTL, 8'h02);
    host.wr(`TFR_A_STAT_CMD, 8'h20);
    done(1'b0, 8'h00, 8'h00, 8'h01, 4'h0);
    ichk(1'b0);
    host.wr(`TFR_A_ALT_DEVCTL, 8'h00);
    ichk(1'b1);
    host.wr(`TFR_A_UNIT_HEAD, 8'hB0);
    ichk(1'b0);
    host.wr(`TFR_A_UNIT_HEAD, 8'hE0);
    ichk(1'b1);
    rchk(`TFR_A_STAT_CMD, 8'h50);
    ichk(1'b0);
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_seek;
    seek_start = 1'b1;
    host.cyc(1);
    seek_start = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h40);
    head_settled = 1'b1;
    host.cyc(1);
    head_settled = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h50);
    host.wr(`TFR_A_STAT_CMD, 8'h20);
    done(1'b1, 8'h04, 8'h00, 8'h01, 4'h0);
    seek_start = 1'b1;
    host.cyc(1);
    seek_start = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h51);
    seek_start = 1'b1;
    host.cyc(1);
    seek_start = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h41);
    low_power_mode = 1'b1;
    host.cyc(1);
    low_power_mode = 1'b0;
    rchk(`TFR_A_STAT_CMD, 8'h51);
    revolution_pulse = 1'b1;
    rchk(`TFR_A_STAT_CMD, 8'h53);
    revolution_pulse = 1'b0;
    host.wr(`TFR_A_SEC_COUNT, 8'h05);
    hard_reset_n = 1'b0;
    host.cyc(4);
    hard_reset_n = 1'b1;
    host.cyc(6);
    rchk(`TFR_A_SEC_COUNT, 8'h01);
    rchk(`TFR_A_STAT_CMD, 8'h50);
    $display("test seek and hard reset done");
  endtask : t_seek
  task automatic t_soft_reset_bit;
    logic [7:0] d;
    soft_reset_bit(8'hCC);
    check(n_rev[7:0], 8'h01);
    rchk(`TFR_A_SEC_COUNT, 8'h01);
    rchk(`TFR_A_UNIT_HEAD, 8'hA0);
    diag_code = 8'h82;
    diag_done = 1'b1;
    host.cyc(1);
    diag_done = 1'b0;
    rchk(`TFR_A_ERR_FEAT, 8'h82);
    cache_flushed = 1'b0;
    soft_reset_bit(8'h66);
    host.rd(`TFR_A_STAT_CMD, d);
    check({7'h0, d[7]}, 8'h01);
    cache_flushed = 1'b1;
    host.cyc(10);
    rchk(`TFR_A_STAT_CMD, 8'h50);
    rchk(`TFR_A_ERR_FEAT, 8'h01);
    check(n_rev[7:0], 8'h01);
    $display("test soft reset done");
  endtask : t_soft_reset_bit
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    host.cyc(10);
    t_reset();
    t_cmd();
    t_irq();
    t_seek();
    t_soft_reset_bit();
    give_verdict();
  end
endmodule : tfr_regs_tb_top
bind tfr_regs tfr_regs_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .hard_reset_n(hard_reset_n), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
  .dior_n(dior_n), .diow_n(diow_n), .dd_oe(dd_oe), .intrq(intrq),
  .core_busy(core_busy), .cache_flushed(cache_flushed), .core_drq(core_drq),
  .cmd_done(cmd_done), .cmd_strobe(cmd_strobe),
  .soft_reset_evt(soft_reset_evt), .revert_defaults(revert_defaults));
`default_nettype wire
